// ==== rtl/codec_spi_control_port.v ====
// serial control port of a multichannel audio codec, slave side
// frame walk, as seen from mclk
// - pins pass two flops, so every link edge is seen two to three cycles late
// - a link period of 125 ns gives about thirty mclk cycles per bit
// - mosi is taken on each of the first sixteen rising link clock edges while select is low
// - bits are held msb first; bit 15 is the first one on the wire
// - after five rising edges the address and read flag are known
// - a peak read loads its level on the sixth and shifts it out on falling edges
// - a write lands when select rises after exactly sixteen edges
// - write_pulse_o marks that cycle; the register views follow one cycle later
// - a word of any other length or with bit 10 set raises the sticky error
// - miso_oe_o rises with the first peak data bit on miso and stays high until deselect
// - deselect drops miso_oe_o within three mclk cycles
// limitations
// - control slots read back nothing; a read of one is a plain refused word
// - peak slots keep a written value that nobody reads; harmless, kept simple
// - a select pulse shorter than two mclk cycles may be missed entirely
// - reset does not wait for a frame to end; a cut frame is dropped
// - all outputs come from flops; nothing here is combinational to a pin
`timescale 1ns/100ps
`default_nettype none
`include "codec_spi_consts.vh"
module codec_spi_control_port #(
  parameter WORD_BITS = `WORD_BITS, // bits per command word
  parameter REG_COUNT = `REG_COUNT // addressable registers
) (
  input wire mclk_i, // core clock, 250 MHz
  input wire rst_i, // synchronous reset, high
  input wire serial_clock_line_i, // master serial clock, idles high
  input wire sel_n_i, // slave select from host flag, low active
  input wire mosi_i, // command data from master
  output reg miso_o, // read data to master
  output reg miso_oe_o, // high while codec drives miso
  input wire [9:0] peak_adc1l_i, // adc peak levels, one per channel
  input wire [9:0] peak_adc1r_i, // peak level adc1 right
  input wire [9:0] peak_adc2l_i, // peak level adc2 left
  input wire [9:0] peak_adc2r_i, // peak level adc2 right
  output reg [9:0] dac_ctrl1_o, // dac control 1 contents
  output reg [9:0] adc_ctrl1_o, // adc control 1 contents
  output reg [9:0] adc_ctrl2_o, // adc control 2 contents
  output reg [9:0] adc_ctrl3_o, // adc control 3 contents
  output reg write_pulse_o, // one cycle when a word is applied
  output reg [3:0] write_addr_o, // address of last applied word
  output reg word_error_o // sticky: reserved bit set or short or long word
);
  // peak level registers are the only readable slots
  function is_peak;
    input [3:0] a;
    begin
      is_peak = (a >= `PEAK_FIRST) && (a <= `PEAK_LAST);
    end
  endfunction

  // synchronised pins
  wire sclk_s;
  wire sel_n_s;
  wire mosi_s;
  // link state
  reg sclk_d;
  reg [WORD_BITS-1:0] shift;
  reg [4:0] bit_cnt;
  // stored register file, addressed by slot
  reg [9:0] regs [0:REG_COUNT-1];
  reg [9:0] rd_word;
  reg rd_active;
  reg sel_d;
  integer i;

  // all pins cross into mclk through two flops; clock runs at 8 MHz so sampling holds
  sync2 u_sclk (.clk_i(mclk_i), .rst_i(rst_i), .d_i(serial_clock_line_i), .init_i(1'b1),
    .q_o(sclk_s));
  sync2 u_sel (.clk_i(mclk_i), .rst_i(rst_i), .d_i(sel_n_i), .init_i(1'b1), .q_o(sel_n_s));
  sync2 u_mosi (.clk_i(mclk_i), .rst_i(rst_i), .d_i(mosi_i), .init_i(1'b1), .q_o(mosi_s));

  // idle-high clock: data sampled on rising edge, changed on falling
  wire rise = sclk_s & ~sclk_d;
  wire fall = ~sclk_s & sclk_d;
  wire selected = ~sel_n_s; // select may come from any flag pin
  wire sel_end = sel_d & ~selected; // deselect between words closes one
  wire [3:0] cur_addr = shift[`ADDR_MSB:`ADDR_LSB];

  // peak levels held in flops so a read shifts out one settled value
  wire [39:0] peak_bus = {peak_adc2r_i, peak_adc2l_i, peak_adc1r_i, peak_adc1l_i};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_peak
      reg [9:0] held;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          held <= 10'h000;
        end else begin
          held <= peak_bus[g*10 +: 10];
        end
      end
    end
  endgenerate

  // peak value for the address just shifted in, zero for control slots
  reg [9:0] peak_mux;
  always @* begin
    case (shift[4:1])
      4'hC: peak_mux = g_peak[0].held;
      4'hD: peak_mux = g_peak[1].held;
      4'hE: peak_mux = g_peak[2].held;
      4'hF: peak_mux = g_peak[3].held;
      default: peak_mux = 10'h000;
    endcase
  end

  // last synchronised levels; reset to idle so no false edge follows reset
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sclk_d <= 1'b1;
      sel_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      sel_d <= selected;
    end
  end

  // serial shift, bit count and read data
  // bits past the sixteenth still count, so a long word is refused
  always @(posedge mclk_i) begin
    if (rst_i) begin
      shift <= {WORD_BITS{1'b0}};
      bit_cnt <= 5'h00;
      rd_active <= 1'b0;
      rd_word <= 10'h000;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      if (!selected) begin
        bit_cnt <= 5'h00;
        rd_active <= 1'b0;
        miso_oe_o <= 1'b0;
      end else if (rise) begin
        if (bit_cnt < WORD_BITS) begin
          shift <= {shift[WORD_BITS-2:0], mosi_s}; // msb first
        end
        if (bit_cnt <= WORD_BITS) begin
          bit_cnt <= bit_cnt + 5'h01; // saturates one past a full word
        end
        // after five bits, address and read flag are known
        if (bit_cnt == 5'h04 && mosi_s && is_peak(shift[3:0])) begin
          rd_active <= 1'b1; // read answered only for peak levels
          rd_word <= 10'h000;
        end
        if (bit_cnt == 5'h05 && shift[0] && is_peak(shift[4:1])) begin
          rd_word <= peak_mux;
        end
      end else if (fall && rd_active && bit_cnt >= 5'h06) begin
        // peak data leaves msb first during the data field
        miso_o <= rd_word[9];
        rd_word <= {rd_word[8:0], 1'b0};
        miso_oe_o <= 1'b1;
      end
    end
  end

  // apply a write only on exactly sixteen bits under select; reads never store
  always @(posedge mclk_i) begin
    if (rst_i) begin
      write_pulse_o <= 1'b0;
      write_addr_o <= 4'h0;
      for (i = 0; i < REG_COUNT; i = i + 1) begin
        regs[i] <= `CTRL_RESET; // defaults at reset
      end
    end else begin
      write_pulse_o <= 1'b0;
      if (sel_end && bit_cnt == WORD_BITS[4:0] && !shift[`RW_BIT]) begin
        regs[cur_addr] <= shift[`DATA_MSB:`DATA_LSB];
        write_pulse_o <= 1'b1;
        write_addr_o <= cur_addr;
      end
    end
  end

  // sticky word error; only reset clears it, so no set/clear race exists
  // a host may poll it once after a whole burst of words
  always @(posedge mclk_i) begin
    if (rst_i) begin
      word_error_o <= 1'b0;
    end else if (sel_end && bit_cnt != WORD_BITS[4:0]) begin
      word_error_o <= 1'b1; // short or long word
    end else if (sel_end && shift[`RSVD_BIT]) begin
      word_error_o <= 1'b1; // reserved bit must be zero
    end
  end

  // control register views, one cycle behind the store; aux master bit as written
  // rate and format fields pass out unchanged for the audio side
  always @(posedge mclk_i) begin
    if (rst_i) begin
      dac_ctrl1_o <= `CTRL_RESET;
      adc_ctrl1_o <= `CTRL_RESET;
      adc_ctrl2_o <= `CTRL_RESET;
      adc_ctrl3_o <= `CTRL_RESET;
    end else begin
      dac_ctrl1_o <= regs[`DAC_CTRL1];
      adc_ctrl1_o <= regs[`ADC_CTRL1];
      adc_ctrl2_o <= regs[`ADC_CTRL2];
      adc_ctrl3_o <= regs[`ADC_CTRL3];
    end
  end
endmodule
`default_nettype wire

// ==== inc/codec_spi_consts.vh ====
// constants for the codec serial control port
`ifndef CODEC_SPI_CONSTS_VH
`define CODEC_SPI_CONSTS_VH
`define WORD_BITS 16
`define ADDR_MSB 15
`define ADDR_LSB 12
`define RW_BIT 11
`define RSVD_BIT 10
`define DATA_MSB 9
`define DATA_LSB 0
`define REG_COUNT 16
`define PEAK_FIRST 4'hC
`define PEAK_LAST 4'hF
`define CTRL_RESET 10'h000
`define DAC_CTRL1 4'h0
`define ADC_CTRL1 4'h1
`define ADC_CTRL2 4'h2
`define ADC_CTRL3 4'h3
`define AUX_MS_BIT 9
`endif

// ==== rtl/sync2.v ====
// two-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  input wire clk_i, // sampling clock
  input wire rst_i, // synchronous reset, high
  input wire d_i, // asynchronous level
  input wire init_i, // level both flops take at reset
  output reg q_o // synchronised level
);
  reg meta;
  // first flop feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= init_i;
      q_o <= init_i;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== test/codec_spi_control_port_properties.sv ====
// checker for the codec control port
`timescale 1ns/100ps
`default_nettype none
module codec_spi_control_port_properties (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sel_n_i,
  input wire logic [9:0] dac_ctrl1_o,
  input wire logic [9:0] adc_ctrl1_o,
  input wire logic [9:0] adc_ctrl2_o,
  input wire logic [9:0] adc_ctrl3_o,
  input wire logic write_pulse_o,
  input wire logic [3:0] write_addr_o,
  input wire logic word_error_o,
  input wire logic miso_oe_o
);
  logic [4:0] wr;
  assign wr = {write_pulse_o, write_addr_o};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // a register may move only the cycle after a pulse naming it
  sequence s_one; write_pulse_o ##1 !write_pulse_o; endsequence
  property p_one; write_pulse_o |-> s_one; endproperty
  a_one: assert property (p_one) else $error("long pulse");
  property p_desel; write_pulse_o |-> sel_n_i && $past(sel_n_i, 2); endproperty
  a_desel: assert property (p_desel) else $error("write under select");
  property p_r0; !$stable(dac_ctrl1_o) |-> $past(wr) == 5'h10; endproperty
  a_r0: assert property (p_r0) else $error("stray dac1 change");
  property p_r1; !$stable(adc_ctrl1_o) |-> $past(wr) == 5'h11; endproperty
  a_r1: assert property (p_r1) else $error("stray adc1 change");
  property p_r2; !$stable(adc_ctrl2_o) |-> $past(wr) == 5'h12; endproperty
  a_r2: assert property (p_r2) else $error("stray adc2 change");
  property p_r3; !$stable(adc_ctrl3_o) |-> $past(wr) == 5'h13; endproperty
  a_r3: assert property (p_r3) else $error("stray adc3 change");
  property p_err; word_error_o |=> word_error_o; endproperty
  a_err: assert property (p_err) else $error("error flag lost");
  property p_rst; $fell(rst_i) |-> {dac_ctrl1_o, adc_ctrl1_o, word_error_o} == 21'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_oe;
    sel_n_i && $past(sel_n_i) && $past(sel_n_i, 2) && $past(sel_n_i, 3) |-> !miso_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("miso driven while deselected");
endmodule
bind codec_spi_control_port codec_spi_control_port_properties i_props (.*);
`default_nettype wire

// ==== test/host_spi_master.sv ====
// host spi master model, flag pin select
`timescale 1ns/100ps
`default_nettype none
module host_spi_master (
  output logic sclk_o, // idles high
  output logic sel_n_o, // low active
  output logic mosi_o, // command bits
  input wire logic miso_i // reply bits
);
  logic [15:0] rx;
  initial begin
    sclk_o = 1'b1;
    sel_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  // n bits msb first; data moves on falls so it is steady at rises
  task automatic xfer(input logic [15:0] w, input int n);
    rx = 16'h0000;
    sel_n_o = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = w[i];
      #62.5 sclk_o = 1'b1;
      rx = {rx[14:0], miso_i};
      #62.5;
    end
    sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #500;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_codec_spi_control_port.sv ====
// bench for the codec control port
`timescale 1ns/100ps
`default_nettype none
module tb_codec_spi_control_port;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] pk_in [4] = '{default: 10'h000};
  logic [9:0] pk [4] = '{10'h2C3, 10'h13C, 10'h3A5, 10'h05A};
  logic [55:0] rows [6] = '{
    {16'h02A5, 10'h2A5, 10'h000, 10'h000, 10'h000},
    {16'h11FF, 10'h2A5, 10'h1FF, 10'h000, 10'h000},
    {16'h2155, 10'h2A5, 10'h1FF, 10'h155, 10'h000},
    {16'h33FF, 10'h2A5, 10'h1FF, 10'h155, 10'h3FF},
    {16'h0801, 10'h2A5, 10'h1FF, 10'h155, 10'h3FF},
    {16'h0000, 10'h000, 10'h1FF, 10'h155, 10'h3FF}};
  wire sclk, sel_n, mosi, miso, pulse, err;
  wire [3:0] waddr;
  wire [9:0] r0, r1, r2, r3;
  int fail_count = 0;
  int comparisons = 0;
  always #2 mclk_i = ~mclk_i;
  host_spi_master i_host (.sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi), .miso_i(miso));
  codec_spi_control_port i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .serial_clock_line_i(sclk),
    .sel_n_i(sel_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(), .peak_adc1l_i(pk_in[0]),
    .peak_adc1r_i(pk_in[1]), .peak_adc2l_i(pk_in[2]), .peak_adc2r_i(pk_in[3]),
    .dac_ctrl1_o(r0), .adc_ctrl1_o(r1), .adc_ctrl2_o(r2), .adc_ctrl3_o(r3),
    .write_pulse_o(pulse), .write_addr_o(waddr), .word_error_o(err));
  task chk(input string n, input logic [40:0] e, s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task do_reset;
    @(posedge mclk_i) rst_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // table rows first, then peak reads, short word, reset and reserved bit
  initial begin
    do_reset;
    foreach (pk_in[k]) pk_in[k] <= pk[k];
    foreach (rows[r]) begin
      i_host.xfer(rows[r][55:40], 16);
      chk("regs", {1'b0, rows[r][39:0]}, {err, r0, r1, r2, r3});
    end
    for (int k = 0; k < 4; k++) begin
      i_host.xfer({4'hC + 4'(k), 12'h800}, 16);
      chk("peak", {31'h0, pk[k]}, {31'h0, i_host.rx[9:0]});
    end
    i_host.xfer(16'h0123, 12);
    chk("short", {1'b1, 10'h000, 10'h1FF, 10'h155, 10'h3FF}, {err, r0, r1, r2, r3});
    do_reset;
    chk("reset", 41'h0, {err, r0, r1, r2, r3});
    i_host.xfer(16'h0755, 16);
    chk("reserved", 41'h1, {40'h0, err});
    chk("reserved_data", {31'h0, 10'h355}, {31'h0, r0});
    i_host.xfer(16'h2000, 16);
    chk("waddr", {37'h0, 4'h2}, {37'h0, waddr});
    give_verdict;
  end
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
